//--- design/iwd_watchdog.sv
/*
 * Independent watchdog top: oscillator time base, prescaler, 12-bit
 * windowed downcounter, start option, debug freeze, reset request.
 * Assumes all inputs synchronous to clk_sys; clk_sys stands in for the
 * watchdog's private clock tree, not the gated core clock.
 */
//
// Summary of operation
// - Eight-bit prescaler divides the watchdog clock
// - Twelve-bit downcounter, refresh only inside window
// - Own 40 kHz time base, not core clock
// - Keeps counting while device is stopped
// - Expiry without refresh requests device reset
// - Timer mode: expiry flags timeout, reloads
// - Option strap picks hardware or software start
// - Debug halt with freeze stops counting
`timescale 1ns/100ps
module iwd_watchdog (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    // Option and configuration
    input  wire logic                      opt_hw_start,
    input  wire iwd_pkg::iwd_mode_t        mode,
    input  wire iwd_pkg::iwd_cfg_t         cfg,
    // Software actions
    input  wire logic                      sw_start,
    input  wire logic                      refresh,
    // System state
    input  wire logic                      stop_mode,
    input  wire logic                      dbg_halt,
    input  wire logic                      dbg_freeze_en,
    // Status and results
    output logic [iwd_pkg::CNT_W-1:0]      count_ff,
    output logic                           running_ff,
    output logic                           timeout_ff,
    output logic                           win_err_ff,
    output logic                           reset_req_ff
);

    logic [iwd_pkg::OSC_DIV_W-1:0] osc_cnt_ff;
    logic                          osc_tick_ff;
    logic                          opt_done_ff;
    logic                          presc_tick;
    logic                          presc_run;
    logic                          frozen;
    logic                          early;
    logic                          legal_refresh;
    logic                          expire;
    logic                          osc_wrap;

    // ----------------------------------------------------------------
    // Decoders
    // ----------------------------------------------------------------
    // Counter sits on its last step
    function automatic logic f_at_zero(
        input logic [iwd_pkg::CNT_W-1:0] value
    );
        return (value == '0);
    endfunction

    function automatic logic f_above_window(
        input logic [iwd_pkg::CNT_W-1:0] value,
        input logic [iwd_pkg::CNT_W-1:0] bound
    );
        return (value > bound);
    endfunction

    // Watchdog resets the device; timer only reports
    function automatic logic f_resets(
        input iwd_pkg::iwd_mode_t sel
    );
        return (sel == iwd_pkg::IWD_MODE_RESET);
    endfunction

    // ----------------------------------------------------------------
    // Qualifiers
    // ----------------------------------------------------------------
    // debug freeze
    assign frozen        = dbg_halt & dbg_freeze_en;
    assign presc_run     = running_ff & ~frozen;

    assign early         = refresh & running_ff & f_above_window(count_ff, cfg.window);

    assign legal_refresh = refresh & ~early;

    // expiry needs a tick at zero
    assign expire        = running_ff & presc_tick & f_at_zero(count_ff)
                           & ~refresh;

    // Oscillator counter at its last state
    assign osc_wrap      = (osc_cnt_ff == iwd_pkg::OSC_LAST);

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    // private 40 kHz tick
    // stop_mode has no gate here
    // Free running: debug freeze only stops the prescaler and clears its count
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_ff <= '0;
        end else if (clk_en) begin
            if (osc_wrap) begin
                osc_cnt_ff <= '0;
            end else begin
                osc_cnt_ff <= osc_cnt_ff + 9'h001;
            end
        end
    end

    // Tick lands one cycle after the wrap
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_tick_ff <= 1'b0;
        end else if (clk_en) begin
            osc_tick_ff <= osc_wrap;
        end
    end

    iwd_prescaler u_presc (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .clk_en      (clk_en),
        .run         (presc_run),
        .div         (cfg.prescale),
        .tick_in     (osc_tick_ff),
        .tick_out_ff (presc_tick)
    );

    // ----------------------------------------------------------------
    // Start control
    // ----------------------------------------------------------------
    // Strap caught once, at the first enabled edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            opt_done_ff <= 1'b0;
        end else if (clk_en) begin
            opt_done_ff <= 1'b1;
        end
    end

    // hardware or software start
    // No stop path, so a stray command cannot disarm it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            running_ff <= 1'b0;
        end else if (clk_en) begin
            if (!opt_done_ff && opt_hw_start) begin
                running_ff <= 1'b1;
            end else if (sw_start) begin
                running_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Downcounter
    // ----------------------------------------------------------------
    // Once started it cannot be stopped short of reset
    // A refresh inside the window outranks a tick landing in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= iwd_pkg::CNT_RST;
        end else if (clk_en) begin
            if (!running_ff) begin
                count_ff <= cfg.reload;
            end else if (legal_refresh) begin
                count_ff <= cfg.reload;
            end else if (presc_tick) begin
                if (f_at_zero(count_ff)) begin
                    count_ff <= cfg.reload;
                end else begin
                    count_ff <= count_ff - 12'h001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Expiry and errors
    // ----------------------------------------------------------------
    // timeout pulse, both modes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timeout_ff <= 1'b0;
        end else if (clk_en) begin
            timeout_ff <= expire;
        end
    end

    // Sticky; only reset clears it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            win_err_ff <= 1'b0;
        end else if (clk_en && early) begin
            win_err_ff <= 1'b1;
        end
    end

    // Reset request is sticky until the device reset clears it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reset_req_ff <= 1'b0;
        end else if (clk_en) begin
            if (expire && f_resets(mode)) begin
                reset_req_ff <= 1'b1;
            end
            if (early && f_resets(mode)) begin
                reset_req_ff <= 1'b1;
            end
        end
    end

endmodule

//--- design/iwd_pkg.sv
/*
 * Package for the independent watchdog: widths, reset values, timing
 * counts and the configuration carrier.
 * Assumes a single clk_sys domain at 20 MHz; no software registers.
 */
package iwd_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PRESC_W = 8;
    localparam int CNT_W   = 12;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0]   CNT_RST   = 12'hfff;
    localparam logic [PRESC_W-1:0] PRESC_RST = 8'h00;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_HZ  = 20_000_000;
    localparam int OSC_HZ      = 40_000;
    localparam int OSC_DIV     = SYS_CLK_HZ / OSC_HZ;
    localparam int OSC_DIV_W   = 9;
    localparam logic [OSC_DIV_W-1:0] OSC_LAST = OSC_DIV_W'(OSC_DIV - 1);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0]   reload;
        logic [CNT_W-1:0]   window;
        logic [PRESC_W-1:0] prescale;
    } iwd_cfg_t;

    typedef enum logic {
        IWD_MODE_RESET,
        IWD_MODE_TIMER
    } iwd_mode_t;

endpackage

//--- design/iwd_prescaler.sv
/*
 * Eight-bit prescaler of the watchdog time base.
 * Assumes tick_in is a one-cycle pulse in clk_sys domain.
 */
`timescale 1ns/100ps
module iwd_prescaler (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    // Control
    input  wire logic                        run,
    input  wire logic [iwd_pkg::PRESC_W-1:0] div,
    input  wire logic                        tick_in,
    // Output
    output logic                             tick_out_ff
);

    logic [iwd_pkg::PRESC_W-1:0] presc_ff;

    // ----------------------------------------------------------------
    // Divide by div+1
    // ----------------------------------------------------------------
    // prescaler count
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            presc_ff    <= iwd_pkg::PRESC_RST;
            tick_out_ff <= 1'b0;
        end else if (clk_en) begin
            tick_out_ff <= 1'b0;
            if (!run) begin
                presc_ff <= iwd_pkg::PRESC_RST;
            end else if (tick_in) begin
                if (presc_ff >= div) begin
                    presc_ff    <= iwd_pkg::PRESC_RST;
                    tick_out_ff <= 1'b1;
                end else begin
                    presc_ff <= presc_ff + 8'h01;
                end
            end
        end
    end

endmodule

//--- verification/iwd_watchdog_asserts.sv
/* Checker for the independent watchdog top.
   Assumes a bind onto iwd_watchdog ports, one clk_sys domain. */
`timescale 1ns/100ps
module iwd_watchdog_chk (
    // Clock and reset
    input wire logic                      clk_sys,
    input wire logic                      rst_n,
    input wire logic                      clk_en,
    // Stimulus seen
    input wire iwd_pkg::iwd_mode_t        mode,
    input wire iwd_pkg::iwd_cfg_t         cfg,
    input wire logic                      sw_start,
    input wire logic                      refresh,
    input wire logic                      dbg_halt,
    input wire logic                      dbg_freeze_en,
    // Results
    input wire logic [iwd_pkg::CNT_W-1:0] count_ff,
    input wire logic                      running_ff,
    input wire logic                      timeout_ff,
    input wire logic                      win_err_ff,
    input wire logic                      reset_req_ff
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic frz = clk_en && dbg_halt && dbg_freeze_en && !refresh;
    wire logic rfr = clk_en && running_ff && refresh;
    property p_start; clk_en && sw_start |=> running_ff; endproperty
    a_start: assert property (p_start) else $error("start ignored");
    property p_run_hold; running_ff |=> running_ff; endproperty
    a_run_hold: assert property (p_run_hold) else $error("counter stopped");
    property p_reload; rfr && count_ff <= cfg.window |=> count_ff == $past(cfg.reload);
    endproperty
    a_reload: assert property (p_reload) else $error("refresh did not reload");
    property p_early; rfr && count_ff > cfg.window |=> win_err_ff; endproperty
    a_early: assert property (p_early) else $error("early refresh unflagged");
    property p_early_rst;
        rfr && count_ff > cfg.window && mode == iwd_pkg::IWD_MODE_RESET |=> reset_req_ff;
    endproperty
    a_early_rst: assert property (p_early_rst) else $error("early refresh no reset");
    property p_exp_rst; timeout_ff && mode == iwd_pkg::IWD_MODE_RESET |-> reset_req_ff;
    endproperty
    a_exp_rst: assert property (p_exp_rst) else $error("expiry without reset");
    // Three cycles: a prescaler pulse already in flight may still land
    property p_freeze; (frz)[*3] |=> $stable(count_ff); endproperty
    a_freeze: assert property (p_freeze) else $error("counted while frozen");
    property p_step;
        running_ff && $changed(count_ff) |-> count_ff == $past(count_ff) - 12'h001
            || count_ff == cfg.reload;
    endproperty
    a_step: assert property (p_step) else $error("counter jumped");
endmodule

//--- verification/test_iwd_watchdog.sv
/* Self-checking bench for the independent watchdog.
   Assumes iwd_pkg and iwd_watchdog compiled first. */
`timescale 1ns/100ps
module test_iwd_watchdog;
    // ----------------------------------------------------------------
    // Signals, clock, design
    // ----------------------------------------------------------------
    logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, opt_hw_start = 1'b0;
    logic sw_start = 1'b0, refresh = 1'b0, stop_mode = 1'b0;
    logic dbg_halt = 1'b0, dbg_freeze_en = 1'b0;
    iwd_pkg::iwd_mode_t mode = iwd_pkg::IWD_MODE_RESET;
    iwd_pkg::iwd_cfg_t cfg = '0;
    logic [iwd_pkg::CNT_W-1:0] count_ff;
    logic running_ff, timeout_ff, win_err_ff, reset_req_ff;
    int mismatches = 0, compares = 0, n;
    always #25 clk_sys = ~clk_sys;
    iwd_watchdog i_dut (.clk_sys, .rst_n, .clk_en, .opt_hw_start, .mode, .cfg, .sw_start,
        .refresh, .stop_mode, .dbg_halt, .dbg_freeze_en, .count_ff, .running_ff,
        .timeout_ff, .win_err_ff, .reset_req_ff);
    task automatic cyc(input int k); repeat (k) @(negedge clk_sys); endtask
    task automatic pulse(ref logic s); s = 1'b1; cyc(1); s = 1'b0; endtask
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic wait_to(input int lim);
        n = 0;
        while (timeout_ff !== 1'b1 && n < lim) begin cyc(1); n++; end
    endtask
    task automatic boot(input logic hw, input iwd_pkg::iwd_mode_t md, input logic [11:0] rl,
        input logic [11:0] win, input logic [7:0] ps);
        rst_n = 1'b0;
        opt_hw_start = hw;
        mode = md;
        cfg = '{rl, win, ps};
        cyc(6);
        rst_n = 1'b1;
        cyc(2);
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        boot(1'b0, iwd_pkg::IWD_MODE_RESET, 12'h005, 12'hfff, 8'h00);
        cmp(running_ff, 1'b0, "started without option");
        cmp(count_ff, 12'h005, "idle count");
        cmp({timeout_ff, win_err_ff, reset_req_ff}, 3'b000, "flags after reset");
        boot(1'b1, iwd_pkg::IWD_MODE_RESET, 12'h005, 12'hfff, 8'h00);
        cmp(running_ff, 1'b1, "option start missing");
        $display("t_reset done");
    endtask
    task automatic t_rate_expire;
        boot(1'b0, iwd_pkg::IWD_MODE_RESET, 12'h005, 12'hfff, 8'h01);
        stop_mode = 1'b1;
        pulse(sw_start);
        cmp(running_ff, 1'b1, "software start");
        n = 0;
        while (count_ff == 12'h005 && n < 2000) begin cyc(1); n++; end
        n = 0;
        while (count_ff == 12'h004 && n < 2000) begin cyc(1); n++; end
        cmp(n, 1000, "decrement period in stop");
        pulse(refresh);
        cmp(count_ff, 12'h005, "refresh reload");
        wait_to(7000);
        cmp(timeout_ff, 1'b1, "no expiry");
        cmp(reset_req_ff, 1'b1, "no reset request");
        stop_mode = 1'b0;
        $display("t_rate_expire done");
    endtask
    task automatic t_timer;
        boot(1'b0, iwd_pkg::IWD_MODE_TIMER, 12'h002, 12'h001, 8'h00);
        pulse(sw_start);
        wait_to(2000);
        cmp(timeout_ff, 1'b1, "no timeout");
        cmp(reset_req_ff, 1'b0, "timer reset device");
        cyc(1);
        cmp(timeout_ff, 1'b0, "timeout not a pulse");
        cmp(count_ff, 12'h002, "timer reload");
        wait_to(2000);
        cmp(timeout_ff, 1'b1, "not free running");
        pulse(refresh);
        cmp(win_err_ff, 1'b1, "timer early refresh");
        cmp(reset_req_ff, 1'b0, "timer early reset");
        $display("t_timer done");
    endtask
    task automatic t_freeze;
        boot(1'b0, iwd_pkg::IWD_MODE_RESET, 12'h00a, 12'hfff, 8'h00);
        dbg_halt = 1'b1;
        dbg_freeze_en = 1'b1;
        pulse(sw_start);
        cyc(2000);
        cmp(count_ff, 12'h00a, "counted in halt");
        dbg_halt = 1'b0;
        cyc(1200);
        cmp(count_ff < 12'h00a, 1'b1, "no count after halt");
        dbg_halt = 1'b1;
        dbg_freeze_en = 1'b0;
        n = count_ff;
        cyc(1200);
        cmp(count_ff < n[11:0], 1'b1, "halt froze without option");
        clk_en = 1'b0;
        n = count_ff;
        cyc(1200);
        cmp(count_ff, n[11:0], "counted with enable low");
        clk_en = 1'b1;
        dbg_halt = 1'b0;
        $display("t_freeze done");
    endtask
    task automatic t_window;
        boot(1'b0, iwd_pkg::IWD_MODE_RESET, 12'h005, 12'h003, 8'h00);
        pulse(sw_start);
        n = 0;
        while (count_ff !== 12'h003 && n < 2500) begin cyc(1); n++; end
        pulse(refresh);
        cmp(count_ff, 12'h005, "boundary refresh");
        cmp(win_err_ff, 1'b0, "boundary flagged");
        cyc(1);
        pulse(refresh);
        cmp(win_err_ff, 1'b1, "early refresh");
        cmp(reset_req_ff, 1'b1, "early no reset");
        $display("t_window done");
    endtask
    // Whole run is near 20000 cycles; limit well above it
    initial begin #(40000 * 50); mismatches++; final_report(); end
    initial begin
        t_reset();
        t_rate_expire();
        t_timer();
        t_freeze();
        t_window();
        final_report();
    end
endmodule
bind iwd_watchdog iwd_watchdog_chk i_chk (.clk_sys, .rst_n, .clk_en, .mode, .cfg, .sw_start,
    .refresh, .dbg_halt, .dbg_freeze_en, .count_ff, .running_ff, .timeout_ff,
    .win_err_ff, .reset_req_ff);
